// ---- hdl/crp_regs.svh ----
// Register map, field positions, reset values and timing counts of the
// codec rate and path control block. Definitions only; no logic.
`ifndef CRP_REGS_SVH
`define CRP_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CRP_OFF_CTRL1 8'h00
`define CRP_OFF_CTRL2 8'h04
`define CRP_OFF_CTRL3 8'h08
`define CRP_OFF_CTRL4 8'h0c
`define CRP_OFF_CTRL5A 8'h10
`define CRP_OFF_CTRL5B 8'h14
`define CRP_OFF_CTRL5C 8'h18
`define CRP_OFF_CTRL6 8'h1c
`define CRP_OFF_STATUS 8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CRP_C1_FIR_SEL 5
`define CRP_C1_ALOOP 2
`define CRP_C1_DLOOP 1
`define CRP_C2_BYPASS 6
`define CRP_C3_OSR_LSB 3
`define CRP_C4_M_LSB 0
`define CRP_C4_N_LSB 7
`define CRP_C4_P_LSB 11
`define CRP_C5C_STG_LSB 3
`define CRP_C5C_PRE_LSB 0
`define CRP_C6_SRC_LSB 1

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define CRP_RST_M_CODE 7'h00
`define CRP_RST_N_CODE 4'h0
`define CRP_RST_P_CODE 3'h7
`define CRP_RST_GAIN 6'h00
`define CRP_GAIN_MUTE 6'h3f
`define CRP_FS_BASE_MULT 5'h10
`define CRP_ADC_OSR 10'h080
`define CRP_FIR_ADC_DELAY 5'h11
`define CRP_FIR_DAC_DELAY 5'h12

`endif

// ---- hdl/crp_pkg.sv ----
// Types shared by the codec rate and path control block.
package crp_pkg;
    typedef enum logic [1:0] {
        CRP_OSR_128 = 2'h0,
        CRP_OSR_256 = 2'h1,
        CRP_OSR_512 = 2'h2
    } crp_osr_t;

    typedef enum logic [1:0] {
        CRP_SRC_LINE = 2'h0,
        CRP_SRC_MIC_SELF = 2'h1,
        CRP_SRC_MIC_PSEUDO = 2'h2,
        CRP_SRC_LINE2 = 2'h3
    } crp_src_t;

    typedef struct packed {
        logic fir_sel;
        logic filt_bypass;
        logic analog_loop_en;
        logic digital_loop_en;
        crp_osr_t dac_oversample_ratio;
        crp_src_t input_source;
        logic [1:0] preamp_gain;
        logic [4:0] adc_group_delay;
        logic [4:0] dac_group_delay;
    } crp_path_cfg_t;
endpackage

// ---- hdl/crp_rate_path_ctrl.sv ----
// Rate dividers, converter tick generation and signal path control of a
// mono voice codec, with an APB register slave.
// Assumes adc/dac sample words arrive from logic on ref_clk, which is the
// master clock of the codec.
//
// Summary of operation
// - Frame sync is master clock over 16*M*N*P
// - Reset selects coarse mode, P equals eight
// - M 1..128, N 1..16, P 1..8 in control four
// - Converter ticks only; serial clocks bypass multiplier
// - Control one D5 picks FIR/IIR decimation
// - Interpolation ticks at 128/256/512 times sample rate
// - Control three D4-D3 sets DAC ratio
// - ADC modulator ticks at 128 times rate
// - Control one D2 enables analog loopback
// - Control one D1 routes ADC words to DAC
// - Analog loopback wins over digital loopback
// - Sidetone attenuates ADC word into DAC input
// - Register 5A D5-D0 sets ADC gain
// - ADC gain changes apply at zero crossing
// - Register 5B sets DAC gain, zero crossing
// - Control six D2-D1 selects input source
// - Register 5C D1-D0 sets preamp gain
// - Control two D6 bypasses filters, rate times four
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "crp_regs.svh"

module crp_rate_path_ctrl import crp_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] adc_word,
    input wire logic [15:0] dac_word,
    output logic frame_sync_strobe,
    output logic adc_mod_tick,
    output logic dac_mod_tick,
    output logic [15:0] adc_out_word,
    output logic [15:0] dac_path_word,
    output logic [5:0] adc_gain_applied,
    output logic [5:0] dac_gain_applied,
    output crp_path_cfg_t path_cfg
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] ctrl1_r, ctrl2_r, ctrl3_r, ctrl5a_r, ctrl5b_r, ctrl5c_r, ctrl6_r;
    logic [6:0] m_code_r;
    logic [3:0] n_code_r;
    logic [2:0] p_code_r;
    logic [6:0] m_act_r;
    logic [3:0] n_act_r;
    logic [2:0] p_act_r;
    logic bypass_act_r;
    logic [20:0] frame_cnt_r;
    logic [20:0] base_period;
    logic [20:0] frame_period;
    logic [21:0] adc_acc_r, dac_acc_r;
    logic [21:0] adc_acc_nxt, dac_acc_nxt;
    logic [9:0] dac_step;
    logic frame_end;
    logic [15:0] frame_count_r;
    logic setup;
    logic wr_en;

    function automatic logic [31:0] crp_rd(input logic [7:0] a, input logic [7:0] c1, input logic [7:0] c2,
                                            input logic [7:0] c3, input logic [13:0] c4, input logic [7:0] c5a,
                                            input logic [7:0] c5b, input logic [7:0] c5c, input logic [7:0] c6,
                                            input logic [15:0] st);
        case (a)
            `CRP_OFF_CTRL1: crp_rd = {24'h0, c1};
            `CRP_OFF_CTRL2: crp_rd = {24'h0, c2};
            `CRP_OFF_CTRL3: crp_rd = {24'h0, c3};
            `CRP_OFF_CTRL4: crp_rd = {18'h0, c4};
            `CRP_OFF_CTRL5A: crp_rd = {24'h0, c5a};
            `CRP_OFF_CTRL5B: crp_rd = {24'h0, c5b};
            `CRP_OFF_CTRL5C: crp_rd = {24'h0, c5c};
            `CRP_OFF_CTRL6: crp_rd = {24'h0, c6};
            `CRP_OFF_STATUS: crp_rd = {16'h0, st};
            default: crp_rd = 32'h0;
        endcase
    endfunction

    function automatic logic crp_mapped(input logic [7:0] a);
        crp_mapped = (a[1:0] == 2'h0) && (a <= `CRP_OFF_STATUS);
    endfunction

    // ----------------------------------------------------------------
    // APB slave: no wait states, answer in the first access cycle
    // ----------------------------------------------------------------
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite && !pslverr;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (clk_en) begin
            pready <= setup;
            if (setup) begin
                pslverr <= !crp_mapped(paddr);
                prdata <= pwrite ? 32'h0 : crp_rd(paddr, ctrl1_r, ctrl2_r, ctrl3_r,
                                                   {p_code_r, n_code_r, m_code_r}, ctrl5a_r, ctrl5b_r,
                                                   ctrl5c_r, ctrl6_r, frame_count_r);
            end else if (!psel) begin
                pslverr <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl1_r <= 8'h00;
            ctrl2_r <= 8'h00;
            ctrl3_r <= 8'h00;
            ctrl5a_r <= 8'h00;
            ctrl5b_r <= 8'h00;
            ctrl5c_r <= 8'h00;
            ctrl6_r <= 8'h00;
            m_code_r <= `CRP_RST_M_CODE;
            n_code_r <= `CRP_RST_N_CODE;
            p_code_r <= `CRP_RST_P_CODE;
        end else if (clk_en && wr_en) begin
            case (paddr)
                `CRP_OFF_CTRL1: ctrl1_r <= pwdata[7:0];
                `CRP_OFF_CTRL2: ctrl2_r <= pwdata[7:0];
                `CRP_OFF_CTRL3: ctrl3_r <= pwdata[7:0];
                `CRP_OFF_CTRL4: begin
                    m_code_r <= pwdata[`CRP_C4_M_LSB +: 7];
                    n_code_r <= pwdata[`CRP_C4_N_LSB +: 4];
                    p_code_r <= pwdata[`CRP_C4_P_LSB +: 3];
                end
                `CRP_OFF_CTRL5A: ctrl5a_r <= pwdata[7:0];
                `CRP_OFF_CTRL5B: ctrl5b_r <= pwdata[7:0];
                `CRP_OFF_CTRL5C: ctrl5c_r <= pwdata[7:0];
                `CRP_OFF_CTRL6: ctrl6_r <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Frame divider
    // ----------------------------------------------------------------
    logic [6:0] m_sel;
    logic [3:0] n_sel;
    logic [2:0] p_sel;
    logic bypass_sel;
    // The reload takes the values being shadowed, so rate and ticks switch together
    assign m_sel = frame_end ? m_code_r : m_act_r;
    assign n_sel = frame_end ? n_code_r : n_act_r;
    assign p_sel = frame_end ? p_code_r : p_act_r;
    assign bypass_sel = frame_end ? ctrl2_r[`CRP_C2_BYPASS] : bypass_act_r;
    assign base_period = 21'(`CRP_FS_BASE_MULT) * 21'({1'b0, m_sel} + 8'h01) *
                         21'({1'b0, n_sel} + 5'h01) * 21'({1'b0, p_sel} + 4'h1);
    assign frame_period = bypass_sel ? {2'h0, base_period[20:2]} : base_period;
    assign frame_end = (frame_cnt_r == 21'h0);

    // Dividers are shadowed so a mid-frame write cannot make a short frame
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            m_act_r <= `CRP_RST_M_CODE;
            n_act_r <= `CRP_RST_N_CODE;
            p_act_r <= `CRP_RST_P_CODE;
            bypass_act_r <= 1'b0;
        end else if (clk_en && frame_end) begin
            m_act_r <= m_code_r;
            n_act_r <= n_code_r;
            p_act_r <= p_code_r;
            bypass_act_r <= ctrl2_r[`CRP_C2_BYPASS];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            frame_cnt_r <= 21'h0;
            frame_sync_strobe <= 1'b0;
            frame_count_r <= 16'h0;
        end else if (clk_en) begin
            frame_sync_strobe <= frame_end;
            if (frame_end) begin
                frame_cnt_r <= 21'(frame_period - 21'h1);
                frame_count_r <= 16'(frame_count_r + 16'h1);
            end else begin
                frame_cnt_r <= 21'(frame_cnt_r - 21'h1);
            end
        end
    end

    // ----------------------------------------------------------------
    // Converter ticks
    // ----------------------------------------------------------------
    // A fractional accumulator stands in for the frequency multiplier; it
    // feeds only converter ticks, never the frame divider. At most one tick
    // per master clock, so tiny M*N*P settings saturate the tick rate.
    always_comb begin
        case (ctrl3_r[`CRP_C3_OSR_LSB +: 2])
            CRP_OSR_256: dac_step = 10'h100;
            CRP_OSR_512: dac_step = 10'h200;
            default: dac_step = 10'h080;
        endcase
        adc_acc_nxt = adc_acc_r + {12'h0, `CRP_ADC_OSR};
        dac_acc_nxt = dac_acc_r + {12'h0, dac_step};
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            adc_acc_r <= 22'h0;
            dac_acc_r <= 22'h0;
            adc_mod_tick <= 1'b0;
            dac_mod_tick <= 1'b0;
        end else if (clk_en) begin
            adc_mod_tick <= (adc_acc_nxt >= {1'b0, base_period});
            adc_acc_r <= (adc_acc_nxt >= {1'b0, base_period}) ? 22'(adc_acc_nxt - {1'b0, base_period})
                                                              : adc_acc_nxt;
            dac_mod_tick <= (dac_acc_nxt >= {1'b0, base_period});
            dac_acc_r <= (dac_acc_nxt >= {1'b0, base_period}) ? 22'(dac_acc_nxt - {1'b0, base_period})
                                                              : dac_acc_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Signal path: loopback, sidetone, gain updates
    // ----------------------------------------------------------------
    logic [15:0] side_word;
    logic [16:0] dac_sum;
    logic dloop_eff;
    logic [15:0] adc_prev_r, dac_prev_r;

    assign dloop_eff = ctrl1_r[`CRP_C1_DLOOP] && !ctrl1_r[`CRP_C1_ALOOP];
    assign side_word = 16'($signed(adc_word) >>> ({1'b0, ctrl5c_r[`CRP_C5C_STG_LSB +: 3]} + 4'h1));
    assign dac_sum = {dloop_eff ? adc_word[15] : dac_word[15], dloop_eff ? adc_word : dac_word} +
                     {side_word[15], side_word};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            adc_out_word <= 16'h0;
            dac_path_word <= 16'h0;
            adc_prev_r <= 16'h0;
            dac_prev_r <= 16'h0;
        end else if (clk_en && frame_end) begin
            adc_out_word <= adc_word;
            adc_prev_r <= adc_word;
            dac_prev_r <= dac_sum[15:0];
            // Saturate instead of wrapping when sidetone pushes past full scale
            if (dac_sum[16] != dac_sum[15]) begin
                dac_path_word <= dac_sum[16] ? 16'h8000 : 16'h7fff;
            end else begin
                dac_path_word <= dac_sum[15:0];
            end
        end
    end

    function automatic logic crp_zero_cross(input logic [15:0] prev, input logic [15:0] cur);
        crp_zero_cross = (cur == 16'h0) || (prev[15] != cur[15]);
    endfunction

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            adc_gain_applied <= `CRP_RST_GAIN;
            dac_gain_applied <= `CRP_RST_GAIN;
        end else if (clk_en && frame_end) begin
            if (crp_zero_cross(adc_prev_r, adc_word)) begin
                adc_gain_applied <= ctrl5a_r[5:0];
            end
            if (crp_zero_cross(dac_prev_r, dac_sum[15:0])) begin
                dac_gain_applied <= ctrl5b_r[5:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            path_cfg <= '0;
        end else if (clk_en) begin
            path_cfg.fir_sel <= ctrl1_r[`CRP_C1_FIR_SEL];
            path_cfg.filt_bypass <= bypass_act_r;
            path_cfg.analog_loop_en <= ctrl1_r[`CRP_C1_ALOOP];
            path_cfg.digital_loop_en <= dloop_eff;
            path_cfg.dac_oversample_ratio <= (ctrl3_r[`CRP_C3_OSR_LSB +: 2] == 2'h3) ? CRP_OSR_128
                                             : crp_osr_t'(ctrl3_r[`CRP_C3_OSR_LSB +: 2]);
            path_cfg.input_source <= crp_src_t'(ctrl6_r[`CRP_C6_SRC_LSB +: 2]);
            path_cfg.preamp_gain <= ctrl5c_r[`CRP_C5C_PRE_LSB +: 2];
            path_cfg.adc_group_delay <= ctrl1_r[`CRP_C1_FIR_SEL] ? `CRP_FIR_ADC_DELAY : 5'h0;
            path_cfg.dac_group_delay <= ctrl1_r[`CRP_C1_FIR_SEL] ? `CRP_FIR_DAC_DELAY : 5'h0;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_FS_PERIOD: assert property (frame_sync_strobe && clk_en && $past(clk_en) |->
        $past(frame_cnt_r) == 21'h0) else $error("frame strobe without terminal count");
    AST_P_RESET: assert property ($rose(!rst) |-> p_act_r == 3'h7) else $error("P not eight after reset");
    AST_DIV_HOLD: assert property (clk_en && !frame_end |=> m_act_r == $past(m_act_r)) else
        $error("divider changed mid frame");
    AST_RELOAD: assert property (clk_en && frame_end |=> frame_cnt_r == $past(frame_period) - 21'h1) else
        $error("frame counter reload wrong");
    AST_BYPASS: assert property (clk_en && frame_end && ctrl2_r[6] |=>
        frame_cnt_r == {2'h0, $past(base_period[20:2])} - 21'h1) else $error("bypass period not quarter");
    AST_ALOOP_WINS: assert property (ctrl1_r[2] && clk_en |=> !path_cfg.digital_loop_en) else
        $error("digital loopback active with analog");
    AST_DLOOP: assert property (clk_en && frame_end && dloop_eff && ctrl5c_r[5:3] == 3'h7 &&
        adc_word[15:8] == 8'h0 |=> dac_path_word == $past(adc_word)) else $error("digital loopback data");
    AST_OSR: assert property (clk_en |=>
        path_cfg.dac_oversample_ratio == ($past(ctrl3_r[4:3]) == 2'h3 ? 2'h0 : $past(ctrl3_r[4:3]))) else
        $error("oversample ratio not followed");
    AST_ADC_GAIN: assert property (clk_en && !frame_end |=> adc_gain_applied == $past(adc_gain_applied)) else
        $error("adc gain changed outside frame");
    AST_DAC_GAIN: assert property (clk_en && !frame_end |=> dac_gain_applied == $past(dac_gain_applied)) else
        $error("dac gain changed outside frame");
    AST_FIR_DELAY: assert property (clk_en && ctrl1_r[5] |=> path_cfg.adc_group_delay == 5'h11 &&
        path_cfg.dac_group_delay == 5'h12) else $error("group delay wrong");
    AST_APB_READY: assert property (psel && !penable && clk_en |=> pready) else
        $error("no answer after setup");

    COV_FRAME: cover property (frame_sync_strobe ##[1:300] frame_sync_strobe);
    COV_BYPASS: cover property (bypass_act_r && frame_sync_strobe);
    COV_WRITE4: cover property (wr_en && paddr == `CRP_OFF_CTRL4);
    COV_GAIN: cover property ($changed(adc_gain_applied));
endmodule

// ---- dv/crp_host_model.sv ----
// Host signal processor stand-in: supplies converter words on ref_clk.
// Assumes frame_sync_strobe is a one-cycle pulse from the block.
`timescale 1ns/1ps
module crp_host_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic frame_sync_strobe,
    input wire logic hold,
    input wire logic [15:0] hold_word,
    output logic [15:0] adc_word,
    output logic [15:0] dac_word
);
    integer seed = 25;

    // ----------------------------------------------------------------
    // Word source
    // ----------------------------------------------------------------
    // Without hold, new words only after a strobe, so each word stands a whole frame
    always @(posedge ref_clk) begin
        if (rst) begin
            adc_word <= 16'h0000;
            dac_word <= 16'h0000;
        end else if (hold) begin
            adc_word <= hold_word;
            dac_word <= hold_word;
        end else if (frame_sync_strobe) begin
            adc_word <= 16'($random(seed));
            dac_word <= 16'($random(seed));
        end
    end
endmodule

// ---- dv/crp_rate_path_ctrl_tb.sv ----
// Self-checking bench of the rate and path control block.
// Assumes crp_host_model feeds the converter words; the APB master is here.
`timescale 1ns/1ps
`include "crp_regs.svh"
module crp_rate_path_ctrl_tb import crp_pkg::*; ;
    logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, fss, amt, dmt, hold = 1'b0;
    logic [15:0] hold_word = 16'h0000, adc_word, dac_word, aow, dpw;
    logic [5:0] aga, dga;
    crp_path_cfg_t path_cfg;
    integer seed = 25;
    int bad_count = 0, samples_checked = 0, cyc = 0, t0, per, at, dt, m, n, p, b, r, prev;

    crp_rate_path_ctrl DUT (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .adc_word(adc_word), .dac_word(dac_word),
        .frame_sync_strobe(fss), .adc_mod_tick(amt), .dac_mod_tick(dmt), .adc_out_word(aow),
        .dac_path_word(dpw), .adc_gain_applied(aga), .dac_gain_applied(dga), .path_cfg(path_cfg));
    crp_host_model host (.ref_clk(ref_clk), .rst(rst), .frame_sync_strobe(fss), .hold(hold),
        .hold_word(hold_word), .adc_word(adc_word), .dac_word(dac_word));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("bad_count=%0d samples_checked=%0d", bad_count, samples_checked);
        if (bad_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic fail(string s);
        bad_count++;
        $display("FAIL t=%0t %s", $time, s);
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) fail($sformatf("value %h, expected %h", got, exp));
    endtask
    task automatic chk_cnt(input int got, input int exp);
        samples_checked++;
        if (got != exp) fail($sformatf("count %0d, expected %0d", got, exp));
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 16) fail("no pready");
    endtask
    // Returns at the edge that closes the strobe cycle; outputs still show that cycle
    task automatic wait_fs();
        int k;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (fss !== 1'b1 && k < 6000);
        if (k >= 6000) fail("no frame strobe");
    endtask
    task automatic measure();
        per = 0;
        at = 0;
        dt = 0;
        do begin
            @(posedge ref_clk);
            per++;
            at += int'(amt === 1'b1);
            dt += int'(dmt === 1'b1);
        end while (fss !== 1'b1 && per < 6000);
    endtask
    function automatic logic [31:0] div_word(int mm, int nn, int pp);
        return {18'h0, 3'(pp - 1), 4'(nn - 1), 7'(mm - 1)};
    endfunction
    // Source word plus ADC word shifted down by code+1, saturated
    function automatic logic [15:0] exp_path(logic [15:0] a, logic [15:0] d, logic dl, int st);
        int s;
        s = $signed(dl ? a : d) + ($signed(a) >>> (st + 1));
        if (s > 32767) return 16'h7fff;
        if (s < -32768) return 16'h8000;
        return 16'(s);
    endfunction

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, `CRP_OFF_CTRL4, 32'h0);
        chk_val(rd, 32'h3800);
        apb(1'b0, 8'h24, 32'h0);
        chk_val({31'h0, err}, 32'h1);
        chk_val(rd, 32'h0);
        apb(1'b0, 8'h02, 32'h0);
        chk_val({31'h0, err}, 32'h1);
        wait_fs();
        measure();
        chk_cnt(per, 128);
        chk_cnt(at, 128);
        // Slow rate keeps every ratio legal for the host
        apb(1'b1, `CRP_OFF_CTRL4, div_word(20, 1, 8));
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `CRP_OFF_CTRL3, 32'(i << 3));
            wait_fs();
            wait_fs();
            measure();
            chk_cnt(per, 2560);
            chk_cnt(at, 128);
            chk_cnt(dt, 128 << (i == 3 ? 0 : i));
            chk_val(path_cfg.dac_oversample_ratio, i == 3 ? 0 : i);
        end
        // Corner dividers first, then random ones the host may legally pick
        prev = 2560;
        for (int i = 0; i < 6; i++) begin
            r = $random(seed) & 3;
            p = (i < 2) ? 1 : (r == 0) ? 1 : (r == 1) ? 2 : 8;
            n = (i == 1) ? 16 : 1 + ($random(seed) & 1);
            m = (i == 0) ? 128 : 1 + ($random(seed) & 7);
            b = (i < 2) ? 0 : $random(seed) & 1;
            if (b == 1) m = 4 * (1 + ($random(seed) & 1));
            wait_fs();
            t0 = cyc;
            apb(1'b1, `CRP_OFF_CTRL4, div_word(m, n, p));
            apb(1'b1, `CRP_OFF_CTRL2, 32'(b << 6));
            wait_fs();
            chk_cnt(cyc - t0, prev);
            t0 = cyc;
            prev = (b == 1) ? 4 * m * n * p : 16 * m * n * p;
            wait_fs();
            chk_cnt(cyc - t0, prev);
            chk_val(path_cfg.filt_bypass, b);
        end
        apb(1'b1, `CRP_OFF_CTRL2, 32'h0);
        apb(1'b1, `CRP_OFF_CTRL4, div_word(1, 1, 2));
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `CRP_OFF_CTRL1, 32'(i[0]) << 5);
            apb(1'b1, `CRP_OFF_CTRL5C, 32'(i));
            apb(1'b1, `CRP_OFF_CTRL6, 32'(i << 1));
            wait_fs();
            wait_fs();
            chk_val({path_cfg.fir_sel, path_cfg.adc_group_delay}, i[0] ? 6'h31 : 6'h00);
            chk_val(path_cfg.dac_group_delay, i[0] ? 18 : 0);
            chk_val(path_cfg.preamp_gain, i);
            chk_val(path_cfg.input_source, i);
        end
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, `CRP_OFF_CTRL5C, 32'(i << 3));
            apb(1'b1, `CRP_OFF_CTRL1, 32'((i & 3) << 1));
            wait_fs();
            wait_fs();
            chk_val(path_cfg.analog_loop_en, i[1]);
            chk_val(path_cfg.digital_loop_en, i[0] & !i[1]);
            chk_val(dpw, exp_path(adc_word, dac_word, i[0] & !i[1], i));
            chk_val(aow, adc_word);
        end
        // A frozen clock enable stretches the frame by exactly the frozen cycles
        wait_fs();
        t0 = cyc;
        clk_en <= 1'b0;
        repeat (10) @(posedge ref_clk);
        clk_en <= 1'b1;
        wait_fs();
        chk_cnt(cyc - t0, 42);
        apb(1'b0, `CRP_OFF_STATUS, 32'h0);
        prev = int'(rd);
        wait_fs();
        apb(1'b0, `CRP_OFF_STATUS, 32'h0);
        chk_cnt(int'(rd) - prev, 1);
        // Gains must wait for a zero or a sign change of the sample
        hold_word <= 16'h0034;
        hold <= 1'b1;
        apb(1'b1, `CRP_OFF_CTRL1, 32'h2);
        wait_fs();
        wait_fs();
        chk_val(dpw, 32'h0034);
        apb(1'b1, `CRP_OFF_CTRL5A, 32'h2a);
        apb(1'b1, `CRP_OFF_CTRL5B, 32'(`CRP_GAIN_MUTE));
        wait_fs();
        wait_fs();
        chk_val(aga, 32'h0);
        chk_val(dga, 32'h0);
        hold_word <= 16'h0000;
        wait_fs();
        wait_fs();
        chk_val(aga, 32'h2a);
        chk_val(dga, 32'h3f);
        end_of_test();
    end

    initial begin
        repeat (95000) @(posedge ref_clk);
        fail("watchdog expired");
        end_of_test();
    end
endmodule
